//--- ojp_regs.vh
`ifndef OJP_REGS_VH
`define OJP_REGS_VH

// Bus register byte offsets
`define OJP_CTRL_OFS 8'h00
`define OJP_BPADDR_OFS 8'h04
`define OJP_STATUS_OFS 8'h08
`define OJP_FLAG_OFS 8'h0C

// Control register fields
`define OJP_CTRL_BP_EN 0
`define OJP_CTRL_BP_CLR 1

// Status register fields
`define OJP_ST_UNLOCKED 0
`define OJP_ST_TEST_MODE 1
`define OJP_ST_BURN_BUSY 2
`define OJP_ST_BP_TRAPPED 3
`define OJP_ST_PMODE_LSB 4
`define OJP_ST_PMODE_MSB 6
`define OJP_ST_TCK_SYSCLK 7

// Setup register fields
`define OJP_SETUP_ADV_MSB 7
`define OJP_SETUP_ADV_LSB 5
`define OJP_SETUP_SKIP 4
`define OJP_SETUP_OE 3
`define OJP_SETUP_PMODE_MSB 2
`define OJP_SETUP_PMODE_LSB 0

// Program mode field values
`define OJP_PMODE_READ 3'h0
`define OJP_PMODE_PROG 3'h2
`define OJP_PMODE_PROG4X 3'h3

// Instruction codes
`define OJP_IR_IDCODE 8'h00
`define OJP_IR_ENTER_TEST 8'hF5
`define OJP_IR_EXIT_TEST 8'hF6
`define OJP_IR_WR_TMODE 8'h70
`define OJP_IR_WR_SETUP 8'h50
`define OJP_IR_WR_ADDR 8'h51
`define OJP_IR_WR_DATA 8'h52
`define OJP_IR_WR_TIMER 8'h54
`define OJP_IR_AUTO_BURN 8'h71
`define OJP_IR_RD_SETUP 8'h60
`define OJP_IR_RD_ADDR 8'h61
`define OJP_IR_RD_DATA 8'h62
`define OJP_IR_RD_TIMER 8'h63
`define OJP_IR_RD_WRCNT 8'h64
`define OJP_IR_AUTO_READ 8'h72
`define OJP_IR_CAPTURE 8'h01

// Memory layout and protection flag
`define OJP_LAST_ADDR 16'hFFFF
`define OJP_FLAG_OPEN 8'hFF
`define OJP_SKIP_STEP 16'h0010

// Test-function value that hands the system clock to TCK
`define OJP_TMODE_TCK_CLK 16'h0002

// TCK cycles per unit of the write-duration setting
`define OJP_WR_UNIT_SHIFT 6
`define OJP_WR_UNIT 64

// Reset values and bus response codes
`define OJP_SETUP_RST 8'h00
`define OJP_TIMER_RST 8'h00
`define OJP_TMODE_RST 16'h0000
`define OJP_RESP_OKAY 2'h0
`define OJP_RESP_SLVERR 2'h2

`endif

//--- ojp_sync.v
`timescale 1ns/1ps
`default_nettype none

module ojp_sync (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Asynchronous level in, synchronised level out
    input wire async_in,
    output reg sync_out
);
    reg meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // ojp_sync

`default_nettype wire

//--- ojp_buf.v
`timescale 1ns/1ps
`default_nettype none

module ojp_buf (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Filling side
    input wire in_valid,
    output wire in_ready,
    input wire [7:0] in_data,
    // Draining side
    output wire out_valid,
    input wire out_ready,
    output wire [7:0] out_data
);
    reg [7:0] mem_q [0:1];
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != 2'd2);
    assign out_valid = (count_q != 2'd0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'd0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'd1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'd1;
            end
        end
    end
endmodule // ojp_buf

`default_nettype wire

//--- ojp_top.v
// Overview of operation
// - Bytes returned to any external reader are scrambled by default until unlocked.
// - Last memory byte is the flag; 0xFF unlocks reads, other values keep scrambling.
// - Unlock happens only after address 0xFFFF is actually read and found 0xFF.
// - Scrambling loses information so true contents cannot be rebuilt from reads.
// - Processor reads of the last byte evaluate the flag exactly like external reads.
// - Boundary-scan port serves debug, or memory access once test mode is entered.
// - Program mode field 2 selects programming, 0 selects reading.
// - TMS and TDI are sampled on every TCK rising edge.
// - TDO changes only on TCK falling edges.
// - Port uses four pins: TCK, TMS, TDI inputs and TDO output.
// - One hardware breakpoint; a new one only after the trapped one is cleared.
// - Instruction 0xF5 enters memory test mode, 0xF6 returns to debug.
// - Test-function value 0x0002 makes TCK the master clock.
// - Each byte write lasts write-duration setting times 64 TCK cycles.
// - Under instruction 0x71 each data load burns a byte and advances the address.
`timescale 1ns/1ps
`default_nettype none
`include "ojp_regs.vh"

module ojp_top #(
    parameter [15:0] ID_CODE = 16'h5A3C // Arbitrary identification value
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Boundary-scan pins
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    // Memory array port
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_we,
    output reg mem_re,
    input wire [7:0] mem_rdata,
    output reg [2:0] mem_program_mode_field,
    output reg mem_oe,
    // Processor read observation and debug
    input wire cpu_rd_valid,
    input wire [15:0] cpu_rd_addr,
    input wire [7:0] cpu_rd_data,
    output reg cpu_halt,
    // Clock selection
    output reg master_clock_from_tck
);
    localparam [3:0] TLR = 4'd0, RTI = 4'd1, SELDR = 4'd2, CAPDR = 4'd3;
    localparam [3:0] SHDR = 4'd4, EX1DR = 4'd5, PADR = 4'd6, EX2DR = 4'd7;
    localparam [3:0] UPDR = 4'd8, SELIR = 4'd9, CAPIR = 4'd10, SHIR = 4'd11;
    localparam [3:0] EX1IR = 4'd12, PAIR = 4'd13, EX2IR = 4'd14, UPIR = 4'd15;
    localparam [1:0] RD_IDLE = 2'd0, RD_WAIT = 2'd1, RD_PUSH = 2'd2;

    wire tck_s;
    wire tms_s;
    wire tdi_s;
    reg tck_prev_q;
    wire tck_rise;
    wire tck_fall;
    reg [3:0] tap_q;
    reg [3:0] tap_d;
    reg [7:0] ir_sh_q;
    reg [7:0] ir_q;
    reg [15:0] dr_sh_q;
    reg test_mode_q;
    reg [7:0] setup_q;
    reg [7:0] timer_q;
    reg [7:0] data_q;
    reg [15:0] tmode_q;
    reg burn_q;
    reg [15:0] wr_cnt_q;
    reg [1:0] rd_st_q;
    reg unlocked_q;
    reg bp_en_q;
    reg [15:0] bp_addr_q;
    reg bp_trapped_q;
    reg aw_full_q;
    reg w_full_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire [2:0] pmode;
    wire rd_allowed;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [7:0] buf_out_data;
    wire buf_pop;
    wire [7:0] rd_byte;
    wire burn_start;
    wire bus_wr;
    wire bp_hit;
    reg [31:0] rd_word;
    reg rd_hit;

    ojp_sync u_sync_tck (.aclk(aclk), .aresetn(aresetn), .async_in(tck), .sync_out(tck_s));
    ojp_sync u_sync_tms (.aclk(aclk), .aresetn(aresetn), .async_in(tms), .sync_out(tms_s));
    ojp_sync u_sync_tdi (.aclk(aclk), .aresetn(aresetn), .async_in(tdi), .sync_out(tdi_s));

    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;
    assign pmode = setup_q[`OJP_SETUP_PMODE_MSB:`OJP_SETUP_PMODE_LSB];
    assign rd_allowed = test_mode_q && (ir_q == `OJP_IR_AUTO_READ) &&
                        (pmode == `OJP_PMODE_READ) && setup_q[`OJP_SETUP_OE];
    assign buf_pop = tck_rise && (tap_q == CAPDR) && (ir_q == `OJP_IR_AUTO_READ);
    assign burn_start = tck_rise && (tap_q == UPDR) && test_mode_q && !burn_q &&
                        (ir_q == `OJP_IR_AUTO_BURN) &&
                        ((pmode == `OJP_PMODE_PROG) || (pmode == `OJP_PMODE_PROG4X));

    // OR with a rotated copy destroys bits, so locked reads cannot be inverted
    assign rd_byte = unlocked_q ? mem_rdata :
                     ((mem_rdata | {mem_rdata[4:0], mem_rdata[7:5]}) ^ mem_addr[7:0]);

    ojp_buf u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(rd_st_q == RD_PUSH),
        .in_ready(buf_in_ready),
        .in_data(data_q),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop),
        .out_data(buf_out_data)
    );

    // Address step is 2^adv; skip mode jumps over each 16-byte hole at [5:4]=00
    function [15:0] next_addr;
        input [15:0] cur;
        input [7:0] setup;
        reg [15:0] nxt;
        begin
            nxt = cur + (16'h0001 << setup[`OJP_SETUP_ADV_MSB:`OJP_SETUP_ADV_LSB]);
            if (setup[`OJP_SETUP_SKIP] && (nxt[5:0] == 6'h00)) begin
                nxt = nxt + `OJP_SKIP_STEP;
            end
            next_addr = nxt;
        end
    endfunction

    always @* begin
        case (tap_q)
            TLR: tap_d = tms_s ? TLR : RTI;
            RTI: tap_d = tms_s ? SELDR : RTI;
            SELDR: tap_d = tms_s ? SELIR : CAPDR;
            CAPDR: tap_d = tms_s ? EX1DR : SHDR;
            SHDR: tap_d = tms_s ? EX1DR : SHDR;
            EX1DR: tap_d = tms_s ? UPDR : PADR;
            PADR: tap_d = tms_s ? EX2DR : PADR;
            EX2DR: tap_d = tms_s ? UPDR : SHDR;
            UPDR: tap_d = tms_s ? SELDR : RTI;
            SELIR: tap_d = tms_s ? TLR : CAPIR;
            CAPIR: tap_d = tms_s ? EX1IR : SHIR;
            SHIR: tap_d = tms_s ? EX1IR : SHIR;
            EX1IR: tap_d = tms_s ? UPIR : PAIR;
            PAIR: tap_d = tms_s ? EX2IR : PAIR;
            EX2IR: tap_d = tms_s ? UPIR : SHIR;
            default: tap_d = tms_s ? SELDR : RTI;
        endcase
    end

    // Scan port: state moves on the sampled TCK rising edge, except TDO which moves on the falling edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            tck_prev_q <= 1'b0;
            tap_q <= TLR;
            ir_sh_q <= 8'h00;
            ir_q <= `OJP_IR_IDCODE;
            dr_sh_q <= 16'h0000;
            tdo <= 1'b0;
            test_mode_q <= 1'b0;
            tmode_q <= `OJP_TMODE_RST;
            setup_q <= `OJP_SETUP_RST;
            timer_q <= `OJP_TIMER_RST;
        end else begin
            tck_prev_q <= tck_s;
            if (tck_rise) begin
                tap_q <= tap_d;
                if (tap_q == CAPIR) begin
                    ir_sh_q <= `OJP_IR_CAPTURE;
                end else if (tap_q == SHIR) begin
                    ir_sh_q <= {tdi_s, ir_sh_q[7:1]};
                end else if (tap_q == UPIR) begin
                    ir_q <= ir_sh_q;
                    if (ir_sh_q == `OJP_IR_ENTER_TEST) begin
                        test_mode_q <= 1'b1;
                    end else if (ir_sh_q == `OJP_IR_EXIT_TEST) begin
                        test_mode_q <= 1'b0;
                    end
                end
                if (tap_q == CAPDR) begin
                    if (!test_mode_q) begin
                        dr_sh_q <= ID_CODE;
                    end else if (ir_q == `OJP_IR_RD_SETUP) begin
                        dr_sh_q <= {8'h00, setup_q};
                    end else if (ir_q == `OJP_IR_RD_ADDR) begin
                        dr_sh_q <= mem_addr;
                    end else if (ir_q == `OJP_IR_RD_DATA) begin
                        dr_sh_q <= {8'h00, data_q};
                    end else if (ir_q == `OJP_IR_RD_TIMER) begin
                        dr_sh_q <= {8'h00, timer_q};
                    end else if (ir_q == `OJP_IR_RD_WRCNT) begin
                        dr_sh_q <= wr_cnt_q;
                    end else if (ir_q == `OJP_IR_AUTO_READ) begin
                        dr_sh_q <= {8'h00, buf_out_valid ? buf_out_data : 8'h00};
                    end
                end else if (tap_q == SHDR) begin
                    dr_sh_q <= {tdi_s, dr_sh_q[15:1]};
                end else if ((tap_q == UPDR) && test_mode_q) begin
                    if (ir_q == `OJP_IR_WR_TMODE) begin
                        tmode_q <= dr_sh_q;
                    end else if (ir_q == `OJP_IR_WR_SETUP) begin
                        setup_q <= dr_sh_q[7:0];
                    end else if (ir_q == `OJP_IR_WR_TIMER) begin
                        timer_q <= dr_sh_q[7:0];
                    end
                end
            end
            if (tck_fall) begin
                if (tap_q == SHIR) begin
                    tdo <= ir_sh_q[0];
                end else if (tap_q == SHDR) begin
                    tdo <= dr_sh_q[0];
                end
            end
        end
    end

    // Memory side: burning, prefetching reads and the protection flag
    always @(posedge aclk) begin
        if (!aresetn) begin
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            mem_program_mode_field <= `OJP_PMODE_READ;
            mem_oe <= 1'b0;
            master_clock_from_tck <= 1'b0;
            data_q <= 8'h00;
            burn_q <= 1'b0;
            wr_cnt_q <= 16'h0000;
            rd_st_q <= RD_IDLE;
            unlocked_q <= 1'b0;
        end else begin
            mem_program_mode_field <= test_mode_q ? pmode : `OJP_PMODE_READ;
            mem_oe <= test_mode_q & setup_q[`OJP_SETUP_OE];
            master_clock_from_tck <= test_mode_q && (tmode_q == `OJP_TMODE_TCK_CLK);
            mem_re <= 1'b0;
            if (tck_rise && (tap_q == UPDR) && test_mode_q && !burn_q) begin
                if (ir_q == `OJP_IR_WR_ADDR) begin
                    mem_addr <= dr_sh_q;
                end else if (ir_q == `OJP_IR_WR_DATA) begin
                    data_q <= dr_sh_q[7:0];
                end
            end
            if (burn_start) begin
                data_q <= dr_sh_q[7:0];
                mem_wdata <= dr_sh_q[7:0];
                mem_we <= 1'b1;
                burn_q <= 1'b1;
                wr_cnt_q <= {8'h00, timer_q} << `OJP_WR_UNIT_SHIFT;
            end else if (burn_q && tck_rise) begin
                if (wr_cnt_q <= 16'h0001) begin
                    mem_we <= 1'b0;
                    burn_q <= 1'b0;
                    wr_cnt_q <= 16'h0000;
                    mem_addr <= next_addr(mem_addr, setup_q);
                end else begin
                    wr_cnt_q <= wr_cnt_q - 16'h0001;
                end
            end
            case (rd_st_q)
                RD_IDLE: begin
                    if (rd_allowed && buf_in_ready && !burn_q) begin
                        mem_re <= 1'b1;
                        rd_st_q <= RD_WAIT;
                    end
                end
                RD_WAIT: begin
                    data_q <= rd_byte;
                    if (mem_addr == `OJP_LAST_ADDR) begin
                        unlocked_q <= (mem_rdata == `OJP_FLAG_OPEN);
                    end
                    rd_st_q <= RD_PUSH;
                end
                default: begin
                    if (buf_in_ready) begin
                        mem_addr <= next_addr(mem_addr, setup_q);
                        rd_st_q <= RD_IDLE;
                    end
                end
            endcase
            if (cpu_rd_valid && (cpu_rd_addr == `OJP_LAST_ADDR)) begin
                unlocked_q <= (cpu_rd_data == `OJP_FLAG_OPEN);
            end
        end
    end

    // Breakpoint: a trap stays until cleared, and the address is frozen meanwhile
    assign bp_hit = bp_en_q && cpu_rd_valid && (cpu_rd_addr == bp_addr_q);
    assign bus_wr = aw_full_q && w_full_q && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            bp_en_q <= 1'b0;
            bp_addr_q <= 16'h0000;
            bp_trapped_q <= 1'b0;
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= bp_trapped_q | bp_hit;
            if (bus_wr && (aw_addr_q == `OJP_CTRL_OFS) && w_strb_q[0]) begin
                bp_en_q <= w_data_q[`OJP_CTRL_BP_EN];
            end
            if (bp_hit) begin
                bp_trapped_q <= 1'b1;
            end else if (bus_wr && (aw_addr_q == `OJP_CTRL_OFS) && w_strb_q[0] &&
                         w_data_q[`OJP_CTRL_BP_CLR]) begin
                bp_trapped_q <= 1'b0;
            end
            if (bus_wr && (aw_addr_q == `OJP_BPADDR_OFS) && !bp_trapped_q) begin
                if (w_strb_q[0]) begin
                    bp_addr_q[7:0] <= w_data_q[7:0];
                end
                if (w_strb_q[1]) begin
                    bp_addr_q[15:8] <= w_data_q[15:8];
                end
            end
        end
    end

    // Register bus: address and data are taken independently, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OJP_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (bus_wr) begin
                s_axi_bvalid <= 1'b1;
                if ((aw_addr_q == `OJP_CTRL_OFS) || (aw_addr_q == `OJP_BPADDR_OFS) ||
                    (aw_addr_q == `OJP_STATUS_OFS) || (aw_addr_q == `OJP_FLAG_OFS)) begin
                    s_axi_bresp <= `OJP_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `OJP_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
        end
    end

    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr == `OJP_CTRL_OFS) begin
            rd_word[`OJP_CTRL_BP_EN] = bp_en_q;
        end else if (s_axi_araddr == `OJP_BPADDR_OFS) begin
            rd_word[15:0] = bp_addr_q;
        end else if (s_axi_araddr == `OJP_STATUS_OFS) begin
            rd_word[`OJP_ST_UNLOCKED] = unlocked_q;
            rd_word[`OJP_ST_TEST_MODE] = test_mode_q;
            rd_word[`OJP_ST_BURN_BUSY] = burn_q;
            rd_word[`OJP_ST_BP_TRAPPED] = bp_trapped_q;
            rd_word[`OJP_ST_PMODE_MSB:`OJP_ST_PMODE_LSB] = mem_program_mode_field;
            rd_word[`OJP_ST_TCK_SYSCLK] = master_clock_from_tck;
        end else if (s_axi_araddr == `OJP_FLAG_OFS) begin
            rd_word[15:0] = mem_addr;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `OJP_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `OJP_RESP_OKAY : `OJP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // ojp_top

`default_nettype wire

//--- ojp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ojp_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched pins
    input wire logic tck,
    input wire logic tdo,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic mem_oe,
    input wire logic [2:0] mem_program_mode_field,
    input wire logic s_axi_arready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic master_clock_from_tck,
    input wire logic cpu_halt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    burn_in_prog_a: assert property ($rose(mem_we) |-> mem_program_mode_field[2:1] == 2'h1)
        else $error("burn started outside program mode");
    read_in_read_a: assert property (mem_re |-> mem_program_mode_field == 3'h0 && mem_oe)
        else $error("memory read outside read mode");
    // Pin edge reaches the output about three cycles late, still inside the low phase
    tdo_on_fall_a: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("serial output moved while clock high");
    reset_clears_a: assert property ($rose(aresetn) |-> !mem_we && !master_clock_from_tck && !cpu_halt)
        else $error("state survived reset");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    wr_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read offered");
endmodule // ojp_checker
bind ojp_top ojp_checker chk (.*);
`default_nettype wire

//--- ojp_jtag_prog.sv
`timescale 1ns/1ps
`default_nettype none
module ojp_jtag_prog (
    // Programmer pins
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo
);
    logic s;
    logic [15:0] q;
    initial begin
        tck = 0;
        tms = 1;
        tdi = 0;
    end
    // Lines move only while the clock is low; clock stands still between frames
    task automatic clk1(input logic m, input logic d);
        tms = m;
        tdi = d;
        #100 tck = 1;
        #100 s = tdo;
        tck = 0;
    endtask
    task automatic tog(input int n);
        for (int i = 0; i < n; i++) clk1(1'b0, 1'b0);
    endtask
    // Scan from idle: instruction 8 bits, data always 16
    task automatic scan(input logic ir, input logic [15:0] v);
        int n;
        n = ir ? 8 : 16;
        #13 clk1(1'b0, 1'b0);
        clk1(1'b1, 1'b0);
        if (ir) clk1(1'b1, 1'b0);
        clk1(1'b0, 1'b0);
        clk1(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            clk1(i == n - 1, v[i]);
            q[i] = s;
        end
        clk1(1'b1, 1'b0);
        clk1(1'b0, 1'b0);
        tdi = ~tdi;
    endtask
endmodule // ojp_jtag_prog
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;
        logic [31:0] q;} ojp_row_t;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, cpu_rd_valid = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mem_rdata = 0, cpu_rd_data = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] cpu_rd_addr = 0;
    logic [1:0] rs;
    int err_count = 0, comparisons = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic tck, tms, tdi, tdo, mem_we, mem_re, mem_oe, cpu_halt, master_clock_from_tck;
    wire logic [15:0] mem_addr;
    wire logic [7:0] mem_wdata;
    wire logic [2:0] mem_program_mode_field;
    ojp_row_t rows [8] = '{'{0, 8'h08, 0, 0, 0}, '{0, 8'h0C, 0, 0, 0}, '{0, 8'h10, 0, 2, 0},
        '{1, 8'h10, 1, 2, 0}, '{1, 8'h04, 32'h0000_1234, 0, 0}, '{1, 8'h00, 1, 0, 0},
        '{0, 8'h04, 0, 0, 32'h0000_1234}, '{0, 8'h00, 0, 0, 1}};
    ojp_top dut (.*);
    ojp_jtag_prog p (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial forever #12.5 aclk = ~aclk;
    // Array byte is address xor 5A; the top byte is the open flag
    always @(posedge aclk)
        mem_rdata <= (mem_addr == 16'hFFFF) ? 8'hFF : mem_addr[7:0] ^ 8'h5A;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {w, w, w};
        {s_axi_arvalid, s_axi_rready} <= {!w, !w};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready));
        rs = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 0;
    endtask
    task automatic cpu(input logic [15:0] a, input logic [7:0] d);
        @(posedge aclk);
        {cpu_rd_valid, cpu_rd_addr, cpu_rd_data} <= {1'b1, a, d};
        @(posedge aclk);
        cpu_rd_valid <= 0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic test_done;
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #2_000_000;
        err_count++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        foreach (rows[i]) begin
            ax(rows[i].w, rows[i].a, rows[i].d);
            chk("resp", rows[i].r, rs);
            if (!rows[i].w) chk("rdata", rows[i].q, rd);
        end
        cpu(16'h1234, 8'h00);
        chk("halt", 1, cpu_halt);
        ax(1, 8'h04, 32'h0000_4444);
        ax(0, 8'h04, 0);
        chk("bp kept", 32'h0000_1234, rd);
        ax(1, 8'h00, 32'h0000_0002);
        repeat (3) @(posedge aclk);
        chk("halt clear", 0, cpu_halt);
        p.scan(1, 8'hF5);
        p.scan(1, 8'h70);
        p.scan(0, 16'h0002);
        chk("tck clock", 1, master_clock_from_tck);
        p.scan(1, 8'h50);
        p.scan(0, 16'h0008);
        p.scan(1, 8'h51);
        p.scan(0, 16'h0205);
        p.scan(1, 8'h72);
        p.scan(0, 0);
        chk("locked byte", (8'h5F | 8'hFA) ^ 8'h05, p.q[7:0]);
        p.scan(1, 8'h51);
        p.scan(0, 16'hFFFF);
        p.scan(1, 8'h72);
        repeat (3) p.scan(0, 0);
        ax(0, 8'h08, 0);
        chk("unlocked", 1, rd[0]);
        for (int k = 0; k < 2; k++) begin
            cpu(16'hFFFF, k ? 8'hFF : 8'h00);
            ax(0, 8'h08, 0);
            chk("cpu flag", k, rd[0]);
        end
        p.scan(1, 8'h50);
        p.scan(0, 16'h000A);
        chk("prog mode", 2, mem_program_mode_field);
        p.scan(1, 8'h54);
        p.scan(0, 16'h0001);
        p.scan(1, 8'h51);
        p.scan(0, 16'h0205);
        p.scan(1, 8'h71);
        p.scan(0, 16'h00A2);
        chk("burn", 32'h0102_05A2, {7'h0, mem_we, mem_addr, mem_wdata});
        p.tog(63);
        chk("burn long", 1, mem_we);
        p.tog(1);
        repeat (4) @(posedge aclk);
        chk("burn end", 32'h0000_0206, {mem_we, mem_addr});
        p.scan(1, 8'hF6);
        chk("exit", 0, {master_clock_from_tck, mem_program_mode_field});
        @(posedge aclk) aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        ax(0, 8'h08, 0);
        chk("relock", 0, rd);
        test_done;
    end
endmodule // tb
`default_nettype wire
